// *** rtl/ims_params.svh ***
// Constants for the idle-mode and reset-status block.
// Assumes the includer uses these names through macros only.
`ifndef IMS_PARAMS_SVH
`define IMS_PARAMS_SVH

// Register word addresses on the plain port
`define IMS_ADDR_RSC      4'h0
`define IMS_ADDR_OSC      4'h1
`define IMS_ADDR_MODE     4'h2

// Status register bit positions
`define IMS_BIT_PRIO      7
`define IMS_BIT_CFGMM     5
`define IMS_BIT_RSTI      4
`define IMS_BIT_WDEXP     3
`define IMS_BIT_PDN       2
`define IMS_BIT_PON       1
`define IMS_BIT_BRN       0

// Oscillator control bit positions
`define IMS_BIT_IDLE_SEL  0
`define IMS_BIT_SCS_LO    1
`define IMS_BIT_SCS_HI    2
`define IMS_BIT_SOSC_EN   3

// Reset value of the status register after power-up
`define IMS_RSC_RESET     8'h3E

// Clock select codes
`define IMS_SCS_PRIMARY   2'h2
`define IMS_SCS_SECOND    2'h1

// Wake ready delay
`define IMS_WAKE_NS       200
`define IMS_CLK_NS        10
`define IMS_WAKE_CYC      ((`IMS_WAKE_NS + `IMS_CLK_NS - 1) / `IMS_CLK_NS)

`endif

// *** rtl/ims_pkg.sv ***
// Types for the idle-mode and reset-status block.
// Assumes ims_params.svh supplies the numeric constants.
package ims_pkg;

  typedef enum logic [2:0] {
    IMS_MAIN_RUN,
    IMS_SECONDARY_CLOCK_RUN,
    IMS_MAIN_IDLE,
    IMS_SECONDARY_CLOCK_IDLE,
    IMS_SEC_WAIT,
    IMS_WAKE
  } ims_state_t;

  // Reset and event causes, one-cycle pulses
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic config_mismatch;
    logic reset_instr;
    logic watchdog_timeout;
    logic watchdog_clear;
    logic power_save;
  } ims_event_t;

  // Clock and CPU status outputs
  typedef struct packed {
    logic cpu_run;
    logic periph_clk_en;
    logic periph_on_secondary;
    logic primary_osc_on;
    logic primary_osc_ready_status;
    logic secondary_clock_active;
  } ims_clk_t;

endpackage

// *** rtl/ims_idle_reset.sv ***
// Idle-mode sequencer and reset-status register.
// Assumes one clock, synchronous inputs and a single-cycle register port.
// Assumes the core turns power-save, watchdog clear and resets into evt pulses.
//
// Implementation choices: the address-and-strobe port and the address map.
`include "ims_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ims_idle_reset (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire ims_pkg::ims_event_t evt,
  input  wire logic             irq_pending,
  input  wire logic             secondary_osc_running,
  input  wire logic             regulator_enabled,
  output logic                  priority_levels_enable,
  output ims_pkg::ims_clk_t     clk_status
);
  import ims_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  ims_state_t  state_reg;
  ims_state_t  state_next;
  logic [7:0]  rsc_reg;
  logic        idle_on_sleep_select_reg;
  logic [1:0]  system_clock_select_reg;
  logic        secondary_osc_enable_reg;
  logic        wake_secondary_reg;
  logic [7:0]  wake_cnt_reg;
  ims_clk_t    clk_next;
  ims_clk_t    clk_reg;
  logic        any_reset;
  logic        wake_evt;
  logic        wr_rsc;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign any_reset = evt.power_on | evt.brownout | evt.config_mismatch | evt.reset_instr;
  assign wake_evt  = irq_pending | evt.watchdog_timeout;
  assign wr_rsc    = reg_wr && (reg_addr == `IMS_ADDR_RSC);

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IMS_MAIN_RUN, IMS_SECONDARY_CLOCK_RUN: begin
        if (evt.power_save && idle_on_sleep_select_reg) begin
          if (system_clock_select_reg == `IMS_SCS_PRIMARY) begin
            state_next = IMS_MAIN_IDLE;
          end else if (system_clock_select_reg == `IMS_SCS_SECOND) begin
            if (!secondary_osc_enable_reg) begin
              state_next = state_reg;
            end else if (!secondary_osc_running) begin
              state_next = IMS_SEC_WAIT;
            end else begin
              state_next = IMS_SECONDARY_CLOCK_IDLE;
            end
          end
        end
      end
      // Peripherals stay gated here rather than run from an unsettled source
      IMS_SEC_WAIT: begin
        if (secondary_osc_running) begin
          state_next = IMS_SECONDARY_CLOCK_IDLE;
        end
      end
      IMS_MAIN_IDLE, IMS_SECONDARY_CLOCK_IDLE: begin
        if (wake_evt) begin
          state_next = IMS_WAKE;
        end
      end
      // Further wake events are ignored here, so the delay is never stretched
      IMS_WAKE: begin
        if (wake_cnt_reg == 8'h01) begin
          state_next = wake_secondary_reg ? IMS_SECONDARY_CLOCK_RUN : IMS_MAIN_RUN;
        end
      end
      default: state_next = IMS_MAIN_RUN;
    endcase
    // Any reset overrides the mode decode above
    if (any_reset) begin
      state_next = IMS_MAIN_RUN;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= IMS_MAIN_RUN;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Wake delay counter
  // ----------------------------------------------------------------
  // Loaded on the wake event, counts down in IMS_WAKE
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_cnt_reg       <= 8'h00;
      wake_secondary_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_next == IMS_WAKE && state_reg != IMS_WAKE) begin
        wake_cnt_reg       <= 8'(`IMS_WAKE_CYC);
        wake_secondary_reg <= (state_reg == IMS_SECONDARY_CLOCK_IDLE);
      end else if (state_reg == IMS_WAKE && wake_cnt_reg != 8'h00) begin
        wake_cnt_reg <= wake_cnt_reg - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator control register, untouched by wake
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_on_sleep_select_reg <= 1'b0;
      system_clock_select_reg  <= 2'h0;
      secondary_osc_enable_reg <= 1'b0;
    end else if (clk_en) begin
      // The secondary enable survives resets so a running oscillator keeps going
      if (any_reset) begin
        idle_on_sleep_select_reg <= 1'b0;
        system_clock_select_reg  <= 2'h0;
      end else if (reg_wr && reg_addr == `IMS_ADDR_OSC) begin
        idle_on_sleep_select_reg <= reg_wdata[`IMS_BIT_IDLE_SEL];
        system_clock_select_reg  <= reg_wdata[`IMS_BIT_SCS_HI:`IMS_BIT_SCS_LO];
        secondary_osc_enable_reg <= reg_wdata[`IMS_BIT_SOSC_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock status
  // ----------------------------------------------------------------
  always_comb begin
    clk_next = clk_reg;
    // Status follows state_next so the flags move on the same edge as the mode
    case (state_next)
      IMS_MAIN_RUN, IMS_MAIN_IDLE: begin
        clk_next.primary_osc_on           = 1'b1;
        clk_next.primary_osc_ready_status = 1'b1;
        clk_next.secondary_clock_active   = 1'b0;
        clk_next.periph_on_secondary      = 1'b0;
        clk_next.periph_clk_en            = 1'b1;
      end
      IMS_SECONDARY_CLOCK_RUN, IMS_SECONDARY_CLOCK_IDLE: begin
        clk_next.primary_osc_on           = 1'b0;
        clk_next.primary_osc_ready_status = 1'b0;
        clk_next.secondary_clock_active   = 1'b1;
        clk_next.periph_on_secondary      = 1'b1;
        clk_next.periph_clk_en            = 1'b1;
      end
      IMS_SEC_WAIT: begin
        clk_next.primary_osc_on           = 1'b0;
        clk_next.primary_osc_ready_status = 1'b0;
        clk_next.secondary_clock_active   = 1'b1;
        clk_next.periph_on_secondary      = 1'b1;
        clk_next.periph_clk_en            = 1'b0;
      end
      IMS_WAKE: begin
        clk_next.periph_clk_en = 1'b1;
      end
      default: clk_next.periph_clk_en = 1'b1;
    endcase
    clk_next.cpu_run = (state_next == IMS_MAIN_RUN) || (state_next == IMS_SECONDARY_CLOCK_RUN);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_reg <= '{cpu_run:                  1'b1,
                   periph_clk_en:            1'b1,
                   periph_on_secondary:      1'b0,
                   primary_osc_on:           1'b1,
                   primary_osc_ready_status: 1'b1,
                   secondary_clock_active:   1'b0};
    end else if (clk_en) begin
      clk_reg <= clk_next;
    end
  end
  assign clk_status = clk_reg;

  // ----------------------------------------------------------------
  // Reset status register
  // ----------------------------------------------------------------
  // Hardware causes are applied after the software write so a cause in the
  // same cycle as a write wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsc_reg <= `IMS_RSC_RESET;
    end else if (clk_en) begin
      if (wr_rsc) begin
        rsc_reg[`IMS_BIT_PRIO]  <= reg_wdata[`IMS_BIT_PRIO];
        rsc_reg[`IMS_BIT_CFGMM] <= reg_wdata[`IMS_BIT_CFGMM];
        rsc_reg[`IMS_BIT_RSTI]  <= reg_wdata[`IMS_BIT_RSTI];
        rsc_reg[`IMS_BIT_PON]   <= reg_wdata[`IMS_BIT_PON];
        rsc_reg[`IMS_BIT_BRN]   <= reg_wdata[`IMS_BIT_BRN];
      end
      if (evt.power_on) begin
        rsc_reg <= `IMS_RSC_RESET;
        rsc_reg[`IMS_BIT_PON] <= 1'b0;
        rsc_reg[`IMS_BIT_BRN] <= 1'b0;
      end else begin
        if (evt.brownout) begin
          rsc_reg[`IMS_BIT_BRN] <= 1'b0;
        end
        if (evt.config_mismatch) begin
          rsc_reg[`IMS_BIT_CFGMM] <= 1'b0;
        end
        if (evt.reset_instr) begin
          rsc_reg[`IMS_BIT_RSTI] <= 1'b0;
        end
        if (any_reset) begin
          rsc_reg[`IMS_BIT_PRIO] <= 1'b0;
        end
        if (evt.watchdog_timeout) begin
          rsc_reg[`IMS_BIT_WDEXP] <= 1'b0;
        end else if (evt.watchdog_clear || evt.power_save) begin
          rsc_reg[`IMS_BIT_WDEXP] <= 1'b1;
        end
        if (evt.power_save) begin
          rsc_reg[`IMS_BIT_PDN] <= 1'b0;
        end else if (evt.watchdog_clear) begin
          rsc_reg[`IMS_BIT_PDN] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      priority_levels_enable <= 1'b0;
    end else if (clk_en) begin
      priority_levels_enable <= rsc_reg[`IMS_BIT_PRIO];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          // Bit 0 is masked at read time, so the stored flag returns with the regulator
          `IMS_ADDR_RSC: begin
            reg_rdata <= {rsc_reg[7], 1'b0, rsc_reg[5:1],
                          rsc_reg[0] & regulator_enabled};
          end
          `IMS_ADDR_OSC: begin
            reg_rdata <= {4'h0, secondary_osc_enable_reg, system_clock_select_reg,
                          idle_on_sleep_select_reg};
          end
          `IMS_ADDR_MODE: begin
            reg_rdata <= {2'h0, clk_reg};
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // ims_idle_reset

`default_nettype wire

// *** verif/ims_idle_reset_checker.sv ***
// Port-level assertions for the idle-mode and reset-status block.
// Assumes one clock; clk_en drops only around a register write; bound to ims_idle_reset.
`include "ims_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ims_idle_reset_checker (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                clk_en,
  input wire logic [3:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire ims_pkg::ims_event_t evt,
  input wire logic                irq_pending,
  input wire logic                secondary_osc_running,
  input wire logic                regulator_enabled,
  input wire logic                priority_levels_enable,
  input wire ims_pkg::ims_clk_t   clk_status
);
  import ims_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Wake sequence
  // ------------------------------------------------------------
  sequence s_wake_req;
    !clk_status.cpu_run && irq_pending && !$past(irq_pending);
  endsequence
  sequence s_cpu_held;
    !clk_status.cpu_run [*8] ##1 !clk_status.cpu_run [*8] ##1 !clk_status.cpu_run [*5];
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Twenty wait cycles after the wake edge, then the CPU runs on the next one
  AST_WAKE_DELAY: assert property (s_wake_req |-> s_cpu_held ##1 clk_status.cpu_run)
    else $error("wake delay wrong");
  AST_MAIN_IDLE_OSC: assert property (
    !clk_status.cpu_run && !clk_status.periph_on_secondary
    |-> clk_status.primary_osc_on && clk_status.primary_osc_ready_status)
    else $error("primary stopped in main idle");
  AST_SEC_STOPS_PRI: assert property (
    clk_status.periph_on_secondary |-> clk_status.secondary_clock_active
    && !clk_status.primary_osc_on && !clk_status.primary_osc_ready_status)
    else $error("primary still on with secondary");
  AST_SEC_HOLD: assert property (
    clk_status.periph_on_secondary && $past(clk_status.periph_on_secondary)
    && !$past(secondary_osc_running) |-> !clk_status.periph_clk_en)
    else $error("peripheral clock before oscillator runs");
  AST_BIT6_ZERO: assert property (
    reg_rd && reg_addr == `IMS_ADDR_RSC |=> !reg_rdata[6])
    else $error("status bit 6 not zero");
  AST_BRN_OFF: assert property (
    reg_rd && reg_addr == `IMS_ADDR_RSC && !regulator_enabled |=> !reg_rdata[0])
    else $error("brown-out bit set with regulator off");
  AST_PRIO_COPY: assert property (
    clk_en && reg_wr && reg_addr == `IMS_ADDR_RSC && evt == '0
    |-> ##2 priority_levels_enable == $past(reg_wdata[7], 2))
    else $error("priority enable does not follow write");
  AST_RESET_RUN: assert property (
    evt.power_on |=> clk_status.cpu_run && clk_status.primary_osc_on
    && !clk_status.periph_on_secondary)
    else $error("power-on did not return to main run");
endmodule // ims_idle_reset_checker

bind ims_idle_reset ims_idle_reset_checker chk_u (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .evt(evt), .irq_pending(irq_pending), .secondary_osc_running(secondary_osc_running),
  .regulator_enabled(regulator_enabled), .priority_levels_enable(priority_levels_enable),
  .clk_status(clk_status));
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the idle-mode and reset-status block.
// Assumes the checker is bound in; clk_en is dropped once to check the freeze.
`include "ims_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ims_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  ims_event_t evt = '0;
  logic       irq = 1'b0;
  logic       sosc_run = 1'b1;
  logic       reg_on = 1'b1;
  logic       prio_en;
  ims_clk_t   cs;
  logic [7:0] stat;
  logic [7:0] rv;
  logic [7:0] d;
  int         error_cnt = 0;
  int         n_checks = 0;
  int         n;
  always #5 clk = ~clk;
  ims_idle_reset dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .evt(evt), .irq_pending(irq), .secondary_osc_running(sosc_run),
    .regulator_enabled(reg_on), .priority_levels_enable(prio_en), .clk_status(cs));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic pulse(input ims_event_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask
  // Status expected after event i, bit order as in ims_event_t from lsb
  function automatic logic [7:0] exp_evt(input logic [7:0] s, input int i);
    case (i)
      0: s = (s | 8'h08) & 8'hFB;
      1: s = s | 8'h0C;
      2: s = s & 8'hF7;
      3: s = s & 8'h6F;
      4: s = s & 8'h5F;
      5: s = s & 8'h7E;
      default: s = 8'h3C;
    endcase
    return s;
  endfunction
  // Enter idle, release oscillator, wake by interrupt or watchdog time-out, time the resumption
  task automatic idle_cycle(input logic [7:0] oc, input logic [7:0] si, input logic [7:0] sr,
                            input logic wd);
    wr(`IMS_ADDR_OSC, oc);
    pulse(ims_event_t'(7'h01));
    chk({2'h0, cs}, si);
    @(posedge clk);
    sosc_run <= 1'b1;
    @(posedge clk);
    if (wd) begin
      evt <= ims_event_t'(7'h04);
    end else begin
      irq <= 1'b1;
    end
    #1 chk({2'h0, cs}, si | 8'h10);
    n = 0;
    while (cs.cpu_run !== 1'b1 && n < 40) begin
      @(posedge clk);
      evt <= '0;
      #1 n++;
    end
    if (n == 40) begin
      error_cnt++;
      summarize();
    end
    chk({7'h0, n == `IMS_WAKE_CYC + 1}, 8'h01);
    chk({2'h0, cs}, sr);
    rd(`IMS_ADDR_OSC, rv);
    chk(rv, oc);
    @(posedge clk);
    irq <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h799635BD));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk({2'h0, cs}, 8'h36);
    rd(`IMS_ADDR_RSC, rv);
    chk(rv, 8'h3E);
    stat = 8'h3E;
    for (int i = 0; i < 7; i++) begin
      d = 8'($urandom);
      wr(`IMS_ADDR_RSC, d);
      stat = (stat & 8'h0C) | (d & 8'hB3);
      rd(`IMS_ADDR_RSC, rv);
      chk(rv, stat);
      chk({7'h0, prio_en}, {7'h0, d[7]});
      pulse(ims_event_t'(7'h01 << i));
      stat = exp_evt(stat, i);
      rd(`IMS_ADDR_RSC, rv);
      chk(rv, stat);
    end
    wr(`IMS_ADDR_RSC, 8'h03);
    stat = (stat & 8'h0C) | 8'h03;
    @(posedge clk);
    reg_on <= 1'b0;
    rd(`IMS_ADDR_RSC, rv);
    chk(rv, stat & 8'hFE);
    @(posedge clk);
    reg_on <= 1'b1;
    pulse(ims_event_t'(7'h20));
    stat = exp_evt(stat, 5);
    rd(`IMS_ADDR_RSC, rv);
    chk({6'h0, rv[1:0]}, 8'h02);
    @(posedge clk);
    ce <= 1'b0;
    wr(`IMS_ADDR_RSC, 8'hB3);
    ce <= 1'b1;
    rd(`IMS_ADDR_RSC, rv);
    chk(rv, stat);
    wr(4'hF, 8'hFF);
    rd(4'hF, rv);
    chk(rv, 8'h00);
    idle_cycle(8'h05, 8'h16, 8'h36, 1'b0);
    idle_cycle(8'h05, 8'h16, 8'h36, 1'b1);
    wr(`IMS_ADDR_OSC, 8'h03);
    pulse(ims_event_t'(7'h01));
    chk({2'h0, cs}, 8'h36);
    @(posedge clk);
    sosc_run <= 1'b0;
    idle_cycle(8'h0B, 8'h09, 8'h39, 1'b0);
    pulse(ims_event_t'(7'h40));
    chk({2'h0, cs}, 8'h36);
    rd(`IMS_ADDR_RSC, rv);
    chk(rv, 8'h3C);
    rd(`IMS_ADDR_MODE, rv);
    chk(rv, 8'h36);
    summarize();
  end
  // A hang anywhere ends the run as a mismatch
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
